// File: logic/wrs_count.sv
// loadable down-counter used for the reset and watchdog timers
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module wrs_count #(
   parameter int W = 24
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   // state
   output logic [W-1:0]      cnt,
   output logic              done
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   // done marks the last cycle of a run of load_val cycles
   always_comb begin
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt = load_val;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign cnt  = cnt_ff;
   assign done = (cnt_ff == W'(1));

endmodule : wrs_count

// File: logic/wrs_pkg.sv
// types shared by the watchdog and reset supervisor
// assumes wrs_regs.svh supplies all numeric constants
package wrs_pkg;

   typedef enum logic [2:0] {
      WRS_ST_NORMAL,
      WRS_ST_STANDBY,
      WRS_ST_SLEEP,
      WRS_ST_RESET,
      WRS_ST_FAILSAFE
   } wrs_state_t;

   typedef enum logic [1:0] {
      WRS_WD_OFF,
      WRS_WD_TIMEOUT,
      WRS_WD_WINDOW
   } wrs_wd_mode_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } wrs_reg_req_t;

endpackage : wrs_pkg

// File: logic/wrs_regs.svh
// register offsets, field positions, reset values and timing figures
// of the watchdog and reset supervisor; definitions only
`ifndef WRS_REGS_SVH
`define WRS_REGS_SVH

// register offsets
`define WRS_ADDR_WD_CTRL    7'h00
`define WRS_ADDR_FAILSAFE   7'h02
`define WRS_ADDR_WD_IRQ     7'h04
`define WRS_ADDR_WD_STAT    7'h05
`define WRS_ADDR_STARTUP    7'h73

// watchdog control fields and codes
`define WRS_WMC_MSB         7
`define WRS_WMC_LSB         5
`define WRS_NWP_MSB         3
`define WRS_NWP_LSB         0
`define WRS_WMC_WINDOW      3'h4
`define WRS_WMC_TIMEOUT     3'h2
`define WRS_WMC_AUTO        3'h1
`define WRS_NWP_RST         4'h0
`define WRS_PHASE_OFF       2'h0
`define WRS_PHASE_FIRST     2'h1
`define WRS_PHASE_SECOND    2'h2

// fail-safe and start-up fields
`define WRS_RCC_MAX         2'h3
`define WRS_RCC_RST         2'h0
`define WRS_STARTUP_MASK    8'h3f
`define WRS_RLC_MSB         5
`define WRS_RLC_LSB         4
`define WRS_AUXSEL_BIT      3
`define WRS_AUX_LOW         2'h0
`define WRS_AUX_HIGH        2'h3
`define WRS_SDM_BIT         2
`define WRS_SYNC_RST        4'hc
`define WRS_PIN_BLANK       2'h3

// timing, in microseconds at a 50 MHz clock
`define WRS_CLK_MHZ         50
`define WRS_TW_RST0_US      20000
`define WRS_TW_RST1_US      10000
`define WRS_TW_RST2_US      3600
`define WRS_TW_RST3_US      1000
`define WRS_TO_RST_US       200000
`define WRS_WD_PERIOD_US    64000
`define WRS_US2CYC(us)      ((us) * `WRS_CLK_MHZ)

`endif

// File: logic/wrs_supervisor.sv
// watchdog mode selection, watchdog control side effects and the
// system reset sequencer with its counter and fail-safe escalation
// assumes the host register port and event inputs run on SYS_CLK;
// pins and supply comparators are asynchronous and are synchronised
`timescale 1ns/1ps
`include "wrs_regs.svh"
// Contract
// - mode code 001 selects Autonomous: watchdog off or Timeout.
// - Autonomous: Timeout in Normal, or Standby with irq low, if sdm 0.
// - watchdog control write restarts timer, phase 01, period start.
// - any system reset enters Reset and drives the reset pin low.
// - entering Reset, counter below 3 is incremented by one.
// - pin held low for reset length, then released, go Standby.
// - counter at 3 on entering Reset goes to fail-safe with limp.
// - no counter increment on battery undervoltage; host clears it.
// - main rail undervoltage during reset restarts the pulse timer.
// - reset time-out increments counter, restarts, or fail-safe at 3.
// - open-drain reset pin is sensed; external pull-down is a reset.
// - cold start after main rail undervoltage uses configured length.
// - other resets always use the shortest 1 ms length; the code gives wake from Sleep and leaving Off/Overload the configured one.
// - length field 5:4 selects 20, 10, 3.6 or 1 ms.
// - start-up bit 3 loads aux regulator control 00 or 11.
// - start-up bits 2..0 enable limp on high-voltage pins 4, 3, 2.
// - reset sources: rail undervoltage, pin, window faults, flag+ovf.
// - reconfiguring watchdog control in Normal causes a reset; the code resets only when the mode code changes.
// - leaving Off/Overload/Sleep, or a refused Sleep, causes a reset.
// - Timeout overflow sets the flag; overflow with flag pending resets.
// - Window: trigger only in second half; early or overflow resets.
// - counter at fail-safe register bits 1:0, read/write, max 3.
module wrs_supervisor #(
   parameter int              TW_W        = 24,
   parameter logic [TW_W-1:0] RST_LEN0_CYC =
      TW_W'(`WRS_US2CYC(`WRS_TW_RST0_US)),
   parameter logic [TW_W-1:0] RST_LEN1_CYC =
      TW_W'(`WRS_US2CYC(`WRS_TW_RST1_US)),
   parameter logic [TW_W-1:0] RST_LEN2_CYC =
      TW_W'(`WRS_US2CYC(`WRS_TW_RST2_US)),
   parameter logic [TW_W-1:0] RST_LEN3_CYC =
      TW_W'(`WRS_US2CYC(`WRS_TW_RST3_US)),
   parameter logic [TW_W-1:0] RST_TIMEOUT_CYC =
      TW_W'(`WRS_US2CYC(`WRS_TO_RST_US)),
   parameter logic [TW_W-1:0] WD_PERIOD_CYC =
      TW_W'(`WRS_US2CYC(`WRS_WD_PERIOD_US))
) (
   // clock and reset
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST_B,
   // register port
   input  wire wrs_pkg::wrs_reg_req_t REG_REQ,
   output logic [7:0]                 REG_RDATA,
   output logic                       REG_RVALID,
   // non-volatile start-up image
   input  wire logic [7:0]            NVM_STARTUP,
   input  wire logic                  SW_DEV_MODE_ENABLE,
   // reset pin, open drain
   input  wire logic                  RESET_PIN_N_IN,
   output logic                       RESET_PIN_N_OUT,
   output logic                       RESET_PIN_N_OE,
   // asynchronous sense inputs
   input  wire logic                  INTERRUPT_REQUEST_PIN_N,
   input  wire logic                  MAIN_SUPPLY_RAIL_UV,
   input  wire logic                  BATTERY_SUPPLY_LEVEL_UV,
   // system events
   input  wire logic                  REQ_NORMAL,
   input  wire logic                  REQ_STANDBY,
   input  wire logic                  REQ_SLEEP,
   input  wire logic                  NO_REGULAR_IRQ,
   input  wire logic                  WAKE_FROM_SLEEP,
   input  wire logic                  LEAVE_OFF_OVERLOAD,
   // status
   output wrs_pkg::wrs_state_t        SYS_STATE,
   output logic [1:0]                 WATCHDOG_PHASE_STATUS,
   output logic                       WATCHDOG_INTERRUPT_FLAG,
   output logic                       LIMP_HOME_ACTIVE,
   output logic [2:0]                 HV_PIN_LIMP_ENABLE,
   output logic [1:0]                 AUX_REGULATOR_CONTROL
);

   // synchronisers: {reset pin, irq pin, main rail uv, battery uv}
   logic [3:0]          sync1_ff;
   logic [3:0]          sync2_ff;
   logic [1:0]          blank_ff;
   logic [1:0]          nxt_blank;

   wrs_pkg::wrs_state_t state_ff;
   wrs_pkg::wrs_state_t nxt_state;
   logic [1:0]          rcc_ff;
   logic [1:0]          nxt_rcc;
   logic                cold_ff;
   logic                nxt_cold;
   logic [2:0]          wmc_ff;
   logic [2:0]          nxt_wmc;
   logic [3:0]          nwp_ff;
   logic [3:0]          nxt_nwp;
   logic                wdi_ff;
   logic                nxt_wdi;
   logic [7:0]          startup_ff;
   logic [7:0]          nxt_startup;
   logic [1:0]          aux_ff;
   logic [1:0]          nxt_aux;
   logic                loaded_ff;
   logic [7:0]          rdata_ff;
   logic [7:0]          nxt_rdata;
   logic                rvalid_ff;

   logic                pin_low_s;
   logic                irq_low_s;
   logic                main_uv_s;
   logic                bat_uv_s;
   logic                driving;
   logic                ext_pull;
   wrs_pkg::wrs_wd_mode_t wd_mode;
   logic [1:0]          phase;
   logic                pls_load;
   logic                to_load;
   logic                wd_load;
   logic                wd_restart;
   logic                wd_rst;
   logic                cfg_err;
   logic                rst_cold;
   logic                rst_req;
   logic                sleep_bad;
   logic [TW_W-1:0]     pls_len;
   logic [TW_W-1:0]     wd_cnt;
   logic                pls_done;
   logic                to_done;
   logic                wd_done;
   logic [1:0]          rcc_inc;

   assign pin_low_s = !sync2_ff[3];
   assign irq_low_s = !sync2_ff[2];
   assign main_uv_s = sync2_ff[1];
   assign bat_uv_s  = sync2_ff[0];
   assign driving   = (state_ff == wrs_pkg::WRS_ST_RESET) ||
                      (state_ff == wrs_pkg::WRS_ST_FAILSAFE);
   // our own release takes two cycles to reach the synchronised sense
   assign ext_pull  = pin_low_s && !driving && (blank_ff == 2'h0);

   always_comb begin
      nxt_blank = blank_ff;
      if (driving) begin
         nxt_blank = `WRS_PIN_BLANK;
      end else if (blank_ff != 2'h0) begin
         nxt_blank = blank_ff - 2'h1;
      end
   end

   // effective watchdog mode from code, state, sdm and irq pin
   always_comb begin
      wd_mode = wrs_pkg::WRS_WD_OFF;
      case (state_ff)
         wrs_pkg::WRS_ST_NORMAL: begin
            if (wmc_ff == `WRS_WMC_WINDOW) begin
               wd_mode = wrs_pkg::WRS_WD_WINDOW;
            end else if (wmc_ff == `WRS_WMC_TIMEOUT) begin
               wd_mode = wrs_pkg::WRS_WD_TIMEOUT;
            end else if (wmc_ff == `WRS_WMC_AUTO &&
                         !SW_DEV_MODE_ENABLE) begin
               wd_mode = wrs_pkg::WRS_WD_TIMEOUT;
            end
         end
         wrs_pkg::WRS_ST_STANDBY: begin
            if (wmc_ff == `WRS_WMC_WINDOW ||
                wmc_ff == `WRS_WMC_TIMEOUT) begin
               wd_mode = wrs_pkg::WRS_WD_TIMEOUT;
            end else if (wmc_ff == `WRS_WMC_AUTO && irq_low_s &&
                         !SW_DEV_MODE_ENABLE) begin
               wd_mode = wrs_pkg::WRS_WD_TIMEOUT;
            end
         end
         wrs_pkg::WRS_ST_SLEEP: begin
            if (wmc_ff == `WRS_WMC_WINDOW ||
                wmc_ff == `WRS_WMC_TIMEOUT) begin
               wd_mode = wrs_pkg::WRS_WD_TIMEOUT;
            end
         end
         default: begin
            wd_mode = wrs_pkg::WRS_WD_OFF;
         end
      endcase
   end

   assign phase = (wd_mode == wrs_pkg::WRS_WD_OFF) ? `WRS_PHASE_OFF :
                  (wd_cnt > (WD_PERIOD_CYC >> 1)) ? `WRS_PHASE_FIRST :
                  `WRS_PHASE_SECOND;
   assign rcc_inc = (rcc_ff == `WRS_RCC_MAX) ? rcc_ff :
                    (bat_uv_s ? rcc_ff : rcc_ff + 2'h1);

   always_comb begin
      nxt_state   = state_ff;
      nxt_rcc     = rcc_ff;
      nxt_cold    = cold_ff;
      nxt_wmc     = wmc_ff;
      nxt_nwp     = nwp_ff;
      nxt_wdi     = wdi_ff;
      nxt_startup = startup_ff;
      nxt_aux     = aux_ff;
      pls_load    = 1'b0;
      to_load     = 1'b0;
      wd_restart  = 1'b0;
      wd_rst      = 1'b0;
      cfg_err     = 1'b0;
      // the start-up image is taken once, after power-up
      if (!loaded_ff) begin
         nxt_startup = NVM_STARTUP & `WRS_STARTUP_MASK;
         nxt_aux     = NVM_STARTUP[`WRS_AUXSEL_BIT] ?
                       `WRS_AUX_HIGH : `WRS_AUX_LOW;
         nxt_wmc     = SW_DEV_MODE_ENABLE ? `WRS_WMC_AUTO :
                       `WRS_WMC_TIMEOUT;
         nxt_cold    = 1'b1;
         pls_load    = 1'b1;
         to_load     = 1'b1;
      end
      if (REG_REQ.wr) begin
         case (REG_REQ.addr)
            `WRS_ADDR_WD_CTRL: begin
               nxt_wmc    = REG_REQ.wdata[`WRS_WMC_MSB:`WRS_WMC_LSB];
               nxt_nwp    = REG_REQ.wdata[`WRS_NWP_MSB:`WRS_NWP_LSB];
               wd_restart = 1'b1;
               if (state_ff == wrs_pkg::WRS_ST_NORMAL &&
                   nxt_wmc != wmc_ff) begin
                  cfg_err = 1'b1;
               end
               if (wd_mode == wrs_pkg::WRS_WD_WINDOW &&
                   phase == `WRS_PHASE_FIRST) begin
                  wd_rst = 1'b1;
               end
            end
            `WRS_ADDR_FAILSAFE: begin
               nxt_rcc = REG_REQ.wdata[1:0];
            end
            `WRS_ADDR_WD_IRQ: begin
               if (REG_REQ.wdata[0]) begin
                  nxt_wdi = 1'b0;
               end
            end
            `WRS_ADDR_STARTUP: begin
               nxt_startup = REG_REQ.wdata & `WRS_STARTUP_MASK;
            end
            default: begin
               nxt_wdi = nxt_wdi;
            end
         endcase
      end
      // overflow: a set of the flag wins over a clear in the same cycle
      if (wd_done && wd_mode != wrs_pkg::WRS_WD_OFF) begin
         wd_restart = 1'b1;
         if (wd_mode == wrs_pkg::WRS_WD_WINDOW || wdi_ff) begin
            wd_rst = 1'b1;
         end else begin
            nxt_wdi = 1'b1;
         end
      end
      rst_cold  = main_uv_s || WAKE_FROM_SLEEP || LEAVE_OFF_OVERLOAD;
      sleep_bad = REQ_SLEEP && (irq_low_s || NO_REGULAR_IRQ);
      rst_req   = rst_cold || ext_pull || wd_rst || cfg_err ||
                  sleep_bad;
      case (state_ff)
         wrs_pkg::WRS_ST_NORMAL, wrs_pkg::WRS_ST_STANDBY,
         wrs_pkg::WRS_ST_SLEEP: begin
            if (rst_req) begin
               if (rcc_ff == `WRS_RCC_MAX) begin
                  nxt_state = wrs_pkg::WRS_ST_FAILSAFE;
               end else begin
                  nxt_state = wrs_pkg::WRS_ST_RESET;
                  nxt_rcc   = rcc_inc;
                  nxt_cold  = rst_cold;
                  nxt_wmc   = SW_DEV_MODE_ENABLE ? `WRS_WMC_AUTO :
                              `WRS_WMC_TIMEOUT;
                  pls_load  = 1'b1;
                  to_load   = 1'b1;
               end
            end else if (REQ_SLEEP &&
                         state_ff != wrs_pkg::WRS_ST_SLEEP) begin
               nxt_state = wrs_pkg::WRS_ST_SLEEP;
            end else if (REQ_NORMAL &&
                         state_ff == wrs_pkg::WRS_ST_STANDBY) begin
               nxt_state = wrs_pkg::WRS_ST_NORMAL;
            end else if (REQ_STANDBY &&
                         state_ff == wrs_pkg::WRS_ST_NORMAL) begin
               nxt_state = wrs_pkg::WRS_ST_STANDBY;
            end
         end
         wrs_pkg::WRS_ST_RESET: begin
            if (to_done && loaded_ff) begin
               nxt_rcc = rcc_inc;
               if (rcc_inc == `WRS_RCC_MAX) begin
                  nxt_state = wrs_pkg::WRS_ST_FAILSAFE;
               end else begin
                  pls_load = 1'b1;
                  to_load  = 1'b1;
               end
            end else if (main_uv_s) begin
               nxt_cold = 1'b1;
               pls_load = 1'b1;
            end else if (pls_done && loaded_ff) begin
               nxt_state = wrs_pkg::WRS_ST_STANDBY;
            end
         end
         wrs_pkg::WRS_ST_FAILSAFE: begin
            nxt_state = wrs_pkg::WRS_ST_FAILSAFE;
         end
         default: begin
            nxt_state = wrs_pkg::WRS_ST_STANDBY;
         end
      endcase
      // cold starts take the configured length, warm ones the shortest
      pls_len = RST_LEN3_CYC;
      if (nxt_cold) begin
         case (nxt_startup[`WRS_RLC_MSB:`WRS_RLC_LSB])
            2'h0:    pls_len = RST_LEN0_CYC;
            2'h1:    pls_len = RST_LEN1_CYC;
            2'h2:    pls_len = RST_LEN2_CYC;
            default: pls_len = RST_LEN3_CYC;
         endcase
      end
   end

   assign wd_load = wd_restart || (wd_mode == wrs_pkg::WRS_WD_OFF);

   always_comb begin
      nxt_rdata = 8'h00;
      case (REG_REQ.addr)
         `WRS_ADDR_WD_CTRL:  nxt_rdata = {wmc_ff, 1'b0, nwp_ff};
         `WRS_ADDR_FAILSAFE: nxt_rdata = {6'h00, rcc_ff};
         `WRS_ADDR_WD_IRQ:   nxt_rdata = {7'h00, wdi_ff};
         `WRS_ADDR_WD_STAT:  nxt_rdata = {5'h00, SW_DEV_MODE_ENABLE,
                                          phase};
         `WRS_ADDR_STARTUP:  nxt_rdata = startup_ff;
         default:            nxt_rdata = 8'h00;
      endcase
   end

   wrs_count #(.W(TW_W)) u_pulse (
      .clk      (SYS_CLK),
      .rst_b    (RST_B),
      .load     (pls_load),
      .load_val (pls_len),
      .cnt      (),
      .done     (pls_done)
   );

   wrs_count #(.W(TW_W)) u_timeout (
      .clk      (SYS_CLK),
      .rst_b    (RST_B),
      .load     (to_load),
      .load_val (RST_TIMEOUT_CYC),
      .cnt      (),
      .done     (to_done)
   );

   wrs_count #(.W(TW_W)) u_wdog (
      .clk      (SYS_CLK),
      .rst_b    (RST_B),
      .load     (wd_load),
      .load_val (WD_PERIOD_CYC),
      .cnt      (wd_cnt),
      .done     (wd_done)
   );

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         sync1_ff   <= `WRS_SYNC_RST;
         sync2_ff   <= `WRS_SYNC_RST;
         blank_ff   <= `WRS_PIN_BLANK;
         state_ff   <= wrs_pkg::WRS_ST_RESET;
         rcc_ff     <= `WRS_RCC_RST;
         cold_ff    <= 1'b1;
         wmc_ff     <= `WRS_WMC_TIMEOUT;
         nwp_ff     <= `WRS_NWP_RST;
         wdi_ff     <= 1'b0;
         startup_ff <= 8'h00;
         aux_ff     <= `WRS_AUX_LOW;
         loaded_ff  <= 1'b0;
         rdata_ff   <= 8'h00;
         rvalid_ff  <= 1'b0;
      end else begin
         sync1_ff   <= {RESET_PIN_N_IN, INTERRUPT_REQUEST_PIN_N,
                        MAIN_SUPPLY_RAIL_UV, BATTERY_SUPPLY_LEVEL_UV};
         sync2_ff   <= sync1_ff;
         blank_ff   <= nxt_blank;
         state_ff   <= nxt_state;
         rcc_ff     <= nxt_rcc;
         cold_ff    <= nxt_cold;
         wmc_ff     <= nxt_wmc;
         nwp_ff     <= nxt_nwp;
         wdi_ff     <= nxt_wdi;
         startup_ff <= nxt_startup;
         aux_ff     <= nxt_aux;
         loaded_ff  <= 1'b1;
         rdata_ff   <= REG_REQ.rd ? nxt_rdata : rdata_ff;
         rvalid_ff  <= REG_REQ.rd;
      end
   end

   assign RESET_PIN_N_OUT         = 1'b0;
   assign RESET_PIN_N_OE          = driving;
   assign REG_RDATA               = rdata_ff;
   assign REG_RVALID              = rvalid_ff;
   assign SYS_STATE               = state_ff;
   assign WATCHDOG_PHASE_STATUS   = phase;
   assign WATCHDOG_INTERRUPT_FLAG = wdi_ff;
   assign LIMP_HOME_ACTIVE        =
      (state_ff == wrs_pkg::WRS_ST_FAILSAFE);
   assign HV_PIN_LIMP_ENABLE      = startup_ff[2:0];
   assign AUX_REGULATOR_CONTROL   = aux_ff;

endmodule : wrs_supervisor

// File: test/test_watchdog_reset_supervisor.sv
// self-checking bench for the watchdog and reset supervisor
// assumes shortened timer counts and the host model on the reset pin
`timescale 1ns/1ps
module test_watchdog_reset_supervisor;
   localparam int LC = 30;
   localparam int LW = 10;
   logic                  sys_clk = 1'b0;
   logic                  rst_b;
   wrs_pkg::wrs_reg_req_t req;
   logic [7:0]            rdata;
   logic                  rvalid;
   logic                  irq_n;
   logic                  bat_uv;
   logic                  req_normal;
   logic                  req_sleep;
   logic                  no_irq;
   logic                  host_go;
   logic                  uv, stby, wk;
   logic                  pin_n;
   logic                  pin_oe;
   wrs_pkg::wrs_state_t   state;
   logic [1:0]            phase;
   logic                  flag;
   logic                  limp;
   logic [2:0]            hv;
   logic [1:0]            aux;
   int                    n_mismatch = 0;
   int                    check_count = 0;
   int                    cyc = 0;

   wrs_supervisor #(
      .RST_LEN0_CYC   (24'd40),
      .RST_LEN1_CYC   (24'd30),
      .RST_LEN2_CYC   (24'd20),
      .RST_LEN3_CYC   (24'd10),
      .RST_TIMEOUT_CYC(24'd200),
      .WD_PERIOD_CYC  (24'd64)
   ) uut (
      .SYS_CLK(sys_clk), .RST_B(rst_b), .REG_REQ(req),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .NVM_STARTUP(8'hdd),
      .SW_DEV_MODE_ENABLE(1'b0), .RESET_PIN_N_IN(pin_n),
      .RESET_PIN_N_OUT(), .RESET_PIN_N_OE(pin_oe),
      .INTERRUPT_REQUEST_PIN_N(irq_n), .MAIN_SUPPLY_RAIL_UV(uv),
      .BATTERY_SUPPLY_LEVEL_UV(bat_uv), .REQ_NORMAL(req_normal),
      .REQ_STANDBY(stby), .REQ_SLEEP(req_sleep), .NO_REGULAR_IRQ(no_irq),
      .WAKE_FROM_SLEEP(wk), .LEAVE_OFF_OVERLOAD(1'b0),
      .SYS_STATE(state), .WATCHDOG_PHASE_STATUS(phase),
      .WATCHDOG_INTERRUPT_FLAG(flag), .LIMP_HOME_ACTIVE(limp),
      .HV_PIN_LIMP_ENABLE(hv), .AUX_REGULATOR_CONTROL(aux)
   );

   wrs_host_model u_host (
      .clk(sys_clk), .go(host_go), .dev_oe(pin_oe), .pin_n(pin_n)
   );

   always #10 sys_clk = ~sys_clk;

   task automatic end_sim();
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge sys_clk);
      req.wr = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge sys_clk);
      req.rd = 1'b0;
      check(8'(rvalid), 8'h01);
      check(rdata, exp);
   endtask : rd_chk

   task automatic wait_st(input wrs_pkg::wrs_state_t s, input int lim);
      int n = 0;
      while (state !== s && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      check(8'(state), 8'(s));
   endtask : wait_st

   task automatic pulse_len(input int len);
      int n = 0;
      while (pin_oe === 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check(8'(n >= len - 1 && n <= len + 2), 8'h01);
   endtask : pulse_len

   task automatic pulse(ref logic sig);
      @(negedge sys_clk);
      sig = 1'b1;
      @(negedge sys_clk);
      sig = 1'b0;
   endtask : pulse

   // autonomous, watchdog off, flag cleared
   task automatic calm();
      wr(7'h00, 8'h20);
      wr(7'h00, 8'h20);
      wr(7'h04, 8'h01);
   endtask : calm

   task automatic t_powerup();
      pulse_len(LC);
      wait_st(wrs_pkg::WRS_ST_STANDBY, 2);
      check(8'(aux), 8'h03);
      check(8'(hv), 8'h05);
      rd_chk(7'h73, 8'h1d);
      rd_chk(7'h10, 8'h00);
      calm();
   endtask : t_powerup

   task automatic t_auto();
      repeat (4) @(negedge sys_clk);
      check(8'(phase), 8'h00);
      irq_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      check(8'(phase != 2'h0), 8'h01);
      irq_n = 1'b1;
      wr(7'h00, 8'h40);
      rd_chk(7'h05, 8'h01);
   endtask : t_auto

   // first overflow flags, a later one resets
   task automatic t_timeout();
      int n;
      wr(7'h02, 8'h00);
      n = 0;
      while (flag !== 1'b1 && n < 80) begin
         @(negedge sys_clk);
         n++;
      end
      check(8'(n >= 50 && n < 80), 8'h01);
      wr(7'h04, 8'h01);
      check(8'(flag), 8'h00);
      wait_st(wrs_pkg::WRS_ST_RESET, 140);
      pulse_len(LW);
      rd_chk(7'h02, 8'h01);
      calm();
   endtask : t_timeout

   task automatic t_pin_uv();
      bat_uv = 1'b1;
      pulse(host_go);
      wait_st(wrs_pkg::WRS_ST_RESET, 8);
      wait_st(wrs_pkg::WRS_ST_STANDBY, 20);
      rd_chk(7'h02, 8'h01);
      bat_uv = 1'b0;
      calm();
   endtask : t_pin_uv

   task automatic t_normal_sleep();
      pulse(req_normal);
      wait_st(wrs_pkg::WRS_ST_NORMAL, 5);
      wr(7'h00, 8'h80);
      wait_st(wrs_pkg::WRS_ST_RESET, 5);
      wait_st(wrs_pkg::WRS_ST_STANDBY, 20);
      calm();
      no_irq = 1'b1;
      pulse(req_sleep);
      wait_st(wrs_pkg::WRS_ST_RESET, 5);
      no_irq = 1'b0;
      wait_st(wrs_pkg::WRS_ST_STANDBY, 20);
      rd_chk(7'h02, 8'h03);
      calm();
   endtask : t_normal_sleep

   task automatic t_failsafe();
      pulse(wk);
      wait_st(wrs_pkg::WRS_ST_FAILSAFE, 8);
      repeat (50) @(negedge sys_clk);
      check(8'(limp), 8'h01);
      check(8'(pin_oe), 8'h01);
   endtask : t_failsafe

   initial begin
      rst_b = 1'b0;
      req = '0;
      irq_n = 1'b1;
      bat_uv = 1'b0;
      req_normal = 1'b0;
      req_sleep = 1'b0;
      no_irq = 1'b0;
      host_go = 1'b0;
      {uv, stby, wk} = '0;
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      t_powerup();
      t_auto();
      t_timeout();
      t_pin_uv();
      t_normal_sleep();
      t_failsafe();
      end_sim();
   end
endmodule : test_watchdog_reset_supervisor

// File: test/wrs_host_model.sv
// host side of the reset pin: pulls the shared pull-up line low
// assumes go is a one-cycle request on the same clock
`timescale 1ns/1ps
module wrs_host_model #(
   parameter int HOLD = 12
) (
   // clock
   input  wire logic clk,
   // pull request and device drive
   input  wire logic go,
   input  wire logic dev_oe,
   // wire level
   output logic      pin_n
);
   int cnt = 0;
   // held past one warm pulse width so the device cannot miss it
   always @(posedge clk) begin
      if (go)
         cnt <= HOLD;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   assign pin_n = !(dev_oe || cnt > 0);
endmodule : wrs_host_model

// File: test/wrs_supervisor_monitor.sv
// port checker for the watchdog and reset supervisor
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
module wrs_supervisor_monitor (
   // clock and reset
   input wire logic                  SYS_CLK,
   input wire logic                  RST_B,
   // register port
   input wire wrs_pkg::wrs_reg_req_t REG_REQ,
   input wire logic [7:0]            REG_RDATA,
   input wire logic                  REG_RVALID,
   // pin and status
   input wire logic                  RESET_PIN_N_OUT,
   input wire logic                  RESET_PIN_N_OE,
   input wire wrs_pkg::wrs_state_t   SYS_STATE,
   input wire logic [1:0]            WATCHDOG_PHASE_STATUS,
   input wire logic                  LIMP_HOME_ACTIVE,
   input wire logic [2:0]            HV_PIN_LIMP_ENABLE,
   input wire logic [1:0]            AUX_REGULATOR_CONTROL
);
   logic in_rst;
   logic in_fs;
   assign in_rst = SYS_STATE == wrs_pkg::WRS_ST_RESET;
   assign in_fs  = SYS_STATE == wrs_pkg::WRS_ST_FAILSAFE;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   a_drive_in_reset: assert property (
      RESET_PIN_N_OE == (in_rst || in_fs)) else $error("pin drive off");
   a_open_drain_low: assert property (
      RESET_PIN_N_OUT == 1'b0) else $error("pin drives high");
   a_limp_in_fs: assert property (
      LIMP_HOME_ACTIVE == in_fs) else $error("limp mismatch");
   a_fs_sticky: assert property (
      in_fs |=> in_fs) else $error("fail-safe left");
   a_release_standby: assert property (
      in_rst ##1 !in_rst |-> SYS_STATE == wrs_pkg::WRS_ST_STANDBY || in_fs)
      else $error("reset not left to standby");
   a_wr_restart: assert property (
      REG_REQ.wr && REG_REQ.addr == 7'h00 && REG_REQ.wdata[7:5] == 3'h2
      && SYS_STATE == wrs_pkg::WRS_ST_STANDBY
      |=> WATCHDOG_PHASE_STATUS == 2'h1) else $error("no restart");
   a_rd_answer: assert property (
      REG_REQ.rd |=> REG_RVALID) else $error("read unanswered");
   a_rcc_width: assert property (
      REG_RVALID && $past(REG_REQ.addr) == 7'h02 |-> REG_RDATA[7:2] == 6'h0)
      else $error("counter wider than two bits");
   a_startup_hold: assert property (
      RST_B && $past(RST_B) && $past(RST_B, 2)
      |-> $stable(HV_PIN_LIMP_ENABLE) && $stable(AUX_REGULATOR_CONTROL))
      else $error("start-up outputs moved");
   a_aux_code: assert property (
      AUX_REGULATOR_CONTROL == 2'h0 || AUX_REGULATOR_CONTROL == 2'h3)
      else $error("aux code illegal");
   c_failsafe: cover property (in_fs);
   c_normal: cover property (SYS_STATE == wrs_pkg::WRS_ST_NORMAL);
   c_release: cover property (in_rst ##1 !in_rst);
endmodule : wrs_supervisor_monitor

bind wrs_supervisor wrs_supervisor_monitor u_mon (
   .SYS_CLK              (SYS_CLK),
   .RST_B                (RST_B),
   .REG_REQ              (REG_REQ),
   .REG_RDATA            (REG_RDATA),
   .REG_RVALID           (REG_RVALID),
   .RESET_PIN_N_OUT      (RESET_PIN_N_OUT),
   .RESET_PIN_N_OE       (RESET_PIN_N_OE),
   .SYS_STATE            (SYS_STATE),
   .WATCHDOG_PHASE_STATUS(WATCHDOG_PHASE_STATUS),
   .LIMP_HOME_ACTIVE     (LIMP_HOME_ACTIVE),
   .HV_PIN_LIMP_ENABLE   (HV_PIN_LIMP_ENABLE),
   .AUX_REGULATOR_CONTROL(AUX_REGULATOR_CONTROL)
);
